/* File: hw/ccpu_params.svh */
// register offsets, field positions and reset values of the capture unit
// assumes word-aligned Avalon-MM byte addresses
`ifndef CCPU_PARAMS_SVH
`define CCPU_PARAMS_SVH

`define CCPU_OFS_CONTROL     4'h0
`define CCPU_OFS_VALUE_LOW   4'h4
`define CCPU_OFS_VALUE_HIGH  4'h8
`define CCPU_OFS_CAP_SOURCE  4'hC
`define CCPU_OFS_TIMER_SEL   5'h10

`define CCPU_BIT_ENABLE      7
`define CCPU_BIT_OUTPUT      5
`define CCPU_BIT_ALIGN       4
`define CCPU_CTRL_WMASK      8'h9F
`define CCPU_CAP_WMASK       8'h07
`define CCPU_RESET_BYTE      8'h00

`define CCPU_MODE_OFF        4'h0
`define CCPU_MODE_TOG_CLR    4'h1
`define CCPU_MODE_TOGGLE     4'h2
`define CCPU_MODE_CAP_BOTH   4'h3
`define CCPU_MODE_CAP_FALL   4'h4
`define CCPU_MODE_CAP_RISE   4'h5
`define CCPU_MODE_CAP_4TH    4'h6
`define CCPU_MODE_CAP_16TH   4'h7
`define CCPU_MODE_SET_OUT    4'h8
`define CCPU_MODE_CLR_OUT    4'h9
`define CCPU_MODE_PULSE      4'hA
`define CCPU_MODE_PULSE_CLR  4'hB

`endif

/* File: hw/ccpu_pkg.sv */
// types shared by the capture/compare/pulse unit
// assumes ccpu_params.svh holds all numbers
`default_nettype none
package ccpu_pkg;
    typedef enum logic [2:0] {
        CCPU_KIND_OFF     = 3'b001,
        CCPU_KIND_CAPTURE = 3'b010,
        CCPU_KIND_COMPARE = 3'b100
    } ccpu_kind_t;
endpackage
`default_nettype wire

/* File: hw/ccpu_unit.sv */
// one capture/compare/pulse-width unit with Avalon-MM registers
// assumes timers, trigger sources and pin routing live outside, same clock
//
// Notes on behaviour
// (RULE1) control bit 7 enables the unit, zero disables it
// (RULE2) control bit 5 reads the output level; writes ignored
// (RULE3) pulse mode, alignment one: duty MSB is high register bit 7
// (RULE4) pulse mode, alignment zero: duty LSB is low register bit 0
// (RULE5) mode 11xx selects pulse-width generation
// (RULE6) 1011 pulses output and clears timer; 1010 pulses output only
// (RULE7) 1001 drives output low, 1000 drives output high on match
// (RULE8) 0010 toggles output; 0001 toggles and clears timer
// (RULE9) capture on 16th, 4th or every rising edge: 0111, 0110, 0101
// (RULE10) capture on falling edge 0100, on either edge 0011
// (RULE11) mode 0000 turns unit off and resets internal state
// (RULE12) timer field 00/01/10 picks first/second/third timer; 11 reserved
// (RULE13) timer select fields at bits 7-6, 5-4, 3-2, 1-0
// (RULE14) capture loads low/high registers from the 16-bit timer
// (RULE15) compare matches the register pair against the 16-bit timer
// (RULE16) right aligned: low gives duty 7..0, high 1..0 gives 9..8
// (RULE17) left aligned: high gives duty 9..2, low 7..6 gives 1..0
// (RULE18) source 000 pin, 001/010 comparators, 011 pin change, 100/101 cells
// (RULE19) reset returns registers to defaults and pin to input
// (RULE20) pulse output feeds internal users and the pin router
// (RULE21) pulse timing follows the system clock
// (RULE22) period end: buffer duty, output high unless duty zero
// (RULE23) output low when 10-bit time base equals buffered duty
// (RULE24) duty above period leaves output unchanged
// (RULE25) software gives the pulse timer a quarter-clock source
// (RULE26) flag pulses on each capture and each compare match
// (RULE27) trigger is synchronised, then edges detected and counted
//
// Chosen here: the Avalon-MM register port and the address map.
`include "ccpu_params.svh"
`default_nettype none
module ccpu_unit (
    input  wire logic        core_clk_in,
    input  wire logic        resetn_in,
    input  wire logic        clk_en_in,
    input  wire logic [4:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    input  wire logic [15:0] sixteen_bit_timer_in,
    input  wire logic [7:0]  period_timer_count_in,
    input  wire logic [2:0]  period_match_in,
    input  wire logic [1:0]  timer_low_bits_in,
    input  wire logic        unit_pin_in,
    input  wire logic        comparator_one_synced_in,
    input  wire logic        comparator_two_synced_in,
    input  wire logic        pin_change_interrupt_in,
    input  wire logic        logic_cell_one_output_in,
    input  wire logic        logic_cell_two_output_in,
    output logic             pulse_out,
    output logic             pin_oe_out,
    output logic             timer_clear_out,
    output logic             event_flag_out,
    output logic      [1:0]  pulse_timer_sel_out
);
    typedef struct packed {
        logic [7:0]  control;
        logic [7:0]  value_low;
        logic [7:0]  value_high;
        logic [2:0]  cap_source;
        logic [7:0]  timer_sel;
        logic [9:0]  duty_buf;
        logic        out_level;
        logic        pulse_hi;
        logic [2:0]  trig_sync;
        logic [3:0]  edge_cnt;
        logic        match_prev;
        logic        timer_clear;
        logic        event_flag;
        logic        ack;
        logic [31:0] rdata;
    } ccpu_state_t;

    ccpu_state_t st_reg;
    ccpu_state_t st_next;

    function automatic ccpu_pkg::ccpu_kind_t kind_of(input logic [3:0] m);
        if (m == `CCPU_MODE_OFF)
            kind_of = ccpu_pkg::CCPU_KIND_OFF;
        else if (m inside {[`CCPU_MODE_CAP_BOTH:`CCPU_MODE_CAP_16TH]})
            kind_of = ccpu_pkg::CCPU_KIND_CAPTURE;
        else
            kind_of = ccpu_pkg::CCPU_KIND_COMPARE;
    endfunction

    logic [3:0]  mode;
    logic        enabled;
    logic        pwm_mode;
    logic [9:0]  duty_reg_val;
    logic [1:0]  tsel;
    logic        sel_trig;
    logic        rise;
    logic        fall;
    logic        cap_hit;
    logic        cmp_eq;
    logic        cmp_hit;
    logic        period_end;
    logic [9:0]  time_base;
    logic [9:0]  tb_next;
    logic        req;
    logic [7:0]  wbyte;

    always_comb begin
        mode     = st_reg.control[3:0];
        enabled  = st_reg.control[`CCPU_BIT_ENABLE];            // [RULE1]
        pwm_mode = &mode[3:2];                                  // [RULE5]
        if (st_reg.control[`CCPU_BIT_ALIGN])                    // [RULE3] [RULE17]
            duty_reg_val = {st_reg.value_high, st_reg.value_low[7:6]};
        else                                                    // [RULE4] [RULE16]
            duty_reg_val = {st_reg.value_high[1:0], st_reg.value_low};
        tsel = st_reg.timer_sel[1:0];                           // [RULE13]
        case (tsel)                                             // [RULE12]
            2'h0:    period_end = period_match_in[0];
            2'h1:    period_end = period_match_in[1];
            2'h2:    period_end = period_match_in[2];
            default: period_end = 1'b0;
        endcase
        case (st_reg.cap_source)                                // [RULE18]
            3'h0:    sel_trig = unit_pin_in;
            3'h1:    sel_trig = comparator_one_synced_in;
            3'h2:    sel_trig = comparator_two_synced_in;
            3'h3:    sel_trig = pin_change_interrupt_in;
            3'h4:    sel_trig = logic_cell_one_output_in;
            3'h5:    sel_trig = logic_cell_two_output_in;
            default: sel_trig = 1'b0;
        endcase
        rise = st_reg.trig_sync[1] & ~st_reg.trig_sync[2];      // [RULE27]
        fall = ~st_reg.trig_sync[1] & st_reg.trig_sync[2];
        time_base = {period_timer_count_in, timer_low_bits_in}; // [RULE23]
        tb_next   = time_base + 10'h001;
        cmp_eq = (sixteen_bit_timer_in ==
                  {st_reg.value_high, st_reg.value_low});       // [RULE15]
        req   = (avs_read_in | avs_write_in) & ~st_reg.ack;
        wbyte = avs_writedata_in[7:0];
    end

    always_comb begin
        st_next = st_reg;
        cap_hit = 1'b0;
        cmp_hit = 1'b0;
        st_next.timer_clear = 1'b0;
        st_next.event_flag  = 1'b0;
        st_next.trig_sync   = {st_reg.trig_sync[1:0], sel_trig}; // [RULE27]
        st_next.match_prev  = cmp_eq;
        // compare pulse lasts one cycle
        if (st_reg.pulse_hi) begin                               // [RULE6]
            st_next.pulse_hi  = 1'b0;
            st_next.out_level = 1'b0;
        end
        if (!enabled || mode == `CCPU_MODE_OFF) begin           // [RULE1] [RULE11]
            st_next.out_level = 1'b0;
            st_next.pulse_hi  = 1'b0;
            st_next.edge_cnt  = 4'h0;
            st_next.duty_buf  = 10'h000;
        end else if (pwm_mode) begin
            if (period_end) begin                               // [RULE22]
                st_next.duty_buf  = duty_reg_val;
                st_next.out_level = (duty_reg_val != 10'h000);
            end else if (tb_next == st_reg.duty_buf) begin      // [RULE23] [RULE24]
                st_next.out_level = 1'b0;
            end
        end else if (kind_of(mode) == ccpu_pkg::CCPU_KIND_CAPTURE) begin
            case (mode)                                         // [RULE9] [RULE10]
                `CCPU_MODE_CAP_BOTH: cap_hit = rise | fall;
                `CCPU_MODE_CAP_FALL: cap_hit = fall;
                `CCPU_MODE_CAP_RISE: cap_hit = rise;
                `CCPU_MODE_CAP_4TH:  cap_hit = rise && st_reg.edge_cnt[1:0] == 2'h3;
                `CCPU_MODE_CAP_16TH: cap_hit = rise && st_reg.edge_cnt == 4'hF;
                default:             cap_hit = 1'b0;
            endcase
            if (rise)
                st_next.edge_cnt = st_reg.edge_cnt + 4'h1;
            if (cap_hit) begin                                  // [RULE14]
                st_next.value_low  = sixteen_bit_timer_in[7:0];
                st_next.value_high = sixteen_bit_timer_in[15:8];
                st_next.event_flag = 1'b1;                      // [RULE26]
            end
        end else begin
            cmp_hit = cmp_eq & ~st_reg.match_prev;
            if (cmp_hit) begin
                st_next.event_flag = 1'b1;                      // [RULE26]
                case (mode)
                    `CCPU_MODE_PULSE_CLR: begin                 // [RULE6]
                        st_next.out_level   = 1'b1;
                        st_next.pulse_hi    = 1'b1;
                        st_next.timer_clear = 1'b1;
                    end
                    `CCPU_MODE_PULSE: begin
                        st_next.out_level = 1'b1;
                        st_next.pulse_hi  = 1'b1;
                    end
                    `CCPU_MODE_CLR_OUT: st_next.out_level = 1'b0; // [RULE7]
                    `CCPU_MODE_SET_OUT: st_next.out_level = 1'b1;
                    `CCPU_MODE_TOGGLE:                          // [RULE8]
                        st_next.out_level = ~st_reg.out_level;
                    `CCPU_MODE_TOG_CLR: begin
                        st_next.out_level   = ~st_reg.out_level;
                        st_next.timer_clear = 1'b1;
                    end
                    default: st_next.out_level = st_reg.out_level;
                endcase
            end
        end
        // bus slave: one wait state, then acknowledge
        st_next.ack = req;
        if (req && avs_write_in) begin
            case (avs_address_in)
                {1'b0, `CCPU_OFS_CONTROL}:                      // [RULE2]
                    st_next.control = wbyte & `CCPU_CTRL_WMASK;
                {1'b0, `CCPU_OFS_VALUE_LOW}:  st_next.value_low  = wbyte;
                {1'b0, `CCPU_OFS_VALUE_HIGH}: st_next.value_high = wbyte;
                {1'b0, `CCPU_OFS_CAP_SOURCE}:
                    st_next.cap_source = wbyte[2:0];
                `CCPU_OFS_TIMER_SEL:          st_next.timer_sel  = wbyte;
                default: st_next.ack = req;
            endcase
        end
        if (req && avs_read_in) begin
            case (avs_address_in)
                {1'b0, `CCPU_OFS_CONTROL}:
                    st_next.rdata = {24'h0, st_reg.control[7:6],
                                     st_reg.out_level, st_reg.control[4:0]};
                {1'b0, `CCPU_OFS_VALUE_LOW}:
                    st_next.rdata = {24'h0, st_reg.value_low};
                {1'b0, `CCPU_OFS_VALUE_HIGH}:
                    st_next.rdata = {24'h0, st_reg.value_high};
                {1'b0, `CCPU_OFS_CAP_SOURCE}:
                    st_next.rdata = {29'h0, st_reg.cap_source};
                `CCPU_OFS_TIMER_SEL:
                    st_next.rdata = {24'h0, st_reg.timer_sel};
                default: st_next.rdata = 32'h0;
            endcase
        end
        if (cap_hit && req && avs_write_in) begin
            st_next.value_low  = sixteen_bit_timer_in[7:0];
            st_next.value_high = sixteen_bit_timer_in[15:8];
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin                                   // [RULE19]
            st_reg <= '0;
        end else if (clk_en_in) begin
            st_reg <= st_next;
        end
    end

    always_comb begin
        avs_readdata_out    = st_reg.rdata;
        avs_waitrequest_out = (avs_read_in | avs_write_in) & ~st_reg.ack;
        pulse_out           = st_reg.out_level;                 // [RULE20] [RULE21]
        pin_oe_out          = enabled && mode != `CCPU_MODE_OFF
                              && kind_of(mode) != ccpu_pkg::CCPU_KIND_CAPTURE;
        timer_clear_out     = st_reg.timer_clear;
        event_flag_out      = st_reg.event_flag;
        pulse_timer_sel_out = tsel;
    end

    pwm_start_a : assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        clk_en_in && enabled && pwm_mode && period_end && duty_reg_val != 10'h0
        |=> pulse_out) else $error("pulse not started at period end"); // [RULE22]
    pwm_zero_a : assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        clk_en_in && enabled && pwm_mode && period_end && duty_reg_val == 10'h0
        |=> !pulse_out) else $error("zero duty drove output"); // [RULE22]
    cap_load_a : assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        clk_en_in && cap_hit |=> event_flag_out &&
        {st_reg.value_high, st_reg.value_low} == $past(sixteen_bit_timer_in))
        else $error("capture value wrong"); // [RULE14]
    cmp_set_a : assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        clk_en_in && cmp_hit && mode == `CCPU_MODE_SET_OUT |=> pulse_out)
        else $error("set on match failed"); // [RULE7]
    cmp_toggle_a : assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        clk_en_in && cmp_hit && mode == `CCPU_MODE_TOGGLE
        |=> pulse_out != $past(pulse_out)) else $error("toggle failed"); // [RULE8]
    sequence pulse_seq;
        pulse_out ##1 !pulse_out;
    endsequence
    cmp_pulse_a : assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        clk_en_in && cmp_hit && mode == `CCPU_MODE_PULSE_CLR
        |=> timer_clear_out and pulse_seq) else $error("pulse mode wrong"); // [RULE6]
    off_level_a : assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        clk_en_in && !enabled |=> !pulse_out) else $error("disabled but high"); // [RULE1]
    out_ro_a : assert property (@(posedge core_clk_in) disable iff (!resetn_in)
        clk_en_in && req && avs_read_in && avs_address_in == 5'h0
        |=> avs_readdata_out[5] == $past(pulse_out)) else $error("out bit wrong"); // [RULE2]
    cmp_clear_a : assert property (@(posedge core_clk_in) // [RULE7]
        disable iff (!resetn_in)
        clk_en_in && cmp_hit && mode == `CCPU_MODE_CLR_OUT |=> !pulse_out)
        else $error("clear on match failed");
    tog_clear_a : assert property (@(posedge core_clk_in) // [RULE8]
        disable iff (!resetn_in)
        clk_en_in && cmp_hit && mode == `CCPU_MODE_TOG_CLR
        |=> timer_clear_out && pulse_out != $past(pulse_out))
        else $error("toggle and clear failed");
    pulse_only_a : assert property (@(posedge core_clk_in) // [RULE6]
        disable iff (!resetn_in)
        clk_en_in && cmp_hit && mode == `CCPU_MODE_PULSE
        |=> (!timer_clear_out) and pulse_seq)
        else $error("plain pulse mode wrong");
    cmp_flag_a : assert property (@(posedge core_clk_in) // [RULE26]
        disable iff (!resetn_in)
        clk_en_in && cmp_hit |=> event_flag_out)
        else $error("no flag on match");
    off_reset_a : assert property (@(posedge core_clk_in) // [RULE11]
        disable iff (!resetn_in)
        clk_en_in && mode == `CCPU_MODE_OFF
        |=> !pulse_out && st_reg.edge_cnt == 4'h0)
        else $error("off mode kept state");
    pwm_clear_a : assert property (@(posedge core_clk_in) // [RULE23]
        disable iff (!resetn_in)
        clk_en_in && enabled && pwm_mode && !period_end
        && tb_next == st_reg.duty_buf |=> !pulse_out)
        else $error("pulse not ended at duty");
    pwm_hold_a : assert property (@(posedge core_clk_in) // [RULE24]
        disable iff (!resetn_in)
        clk_en_in && enabled && pwm_mode && !period_end && !st_reg.pulse_hi
        && tb_next != st_reg.duty_buf |=> pulse_out == $past(pulse_out))
        else $error("pulse level moved");
    pwm_buf_a : assert property (@(posedge core_clk_in) // [RULE22]
        disable iff (!resetn_in)
        clk_en_in && enabled && pwm_mode && period_end
        |=> st_reg.duty_buf == $past(duty_reg_val))
        else $error("duty not buffered");
    align_left_a : assert property (@(posedge core_clk_in) // [RULE3] [RULE17]
        disable iff (!resetn_in)
        clk_en_in && enabled && pwm_mode && period_end
        && st_reg.control[`CCPU_BIT_ALIGN]
        |=> st_reg.duty_buf[9:2] == $past(st_reg.value_high))
        else $error("left alignment wrong");
    align_right_a : assert property (@(posedge core_clk_in) // [RULE4] [RULE16]
        disable iff (!resetn_in)
        clk_en_in && enabled && pwm_mode && period_end
        && !st_reg.control[`CCPU_BIT_ALIGN]
        |=> st_reg.duty_buf[7:0] == $past(st_reg.value_low))
        else $error("right alignment wrong");
    cap_rise_a : assert property (@(posedge core_clk_in) // [RULE9]
        disable iff (!resetn_in)
        clk_en_in && enabled && mode == `CCPU_MODE_CAP_RISE && rise
        |=> event_flag_out)
        else $error("rise not captured");
    cap_fall_a : assert property (@(posedge core_clk_in) // [RULE10]
        disable iff (!resetn_in)
        clk_en_in && enabled && mode == `CCPU_MODE_CAP_FALL && fall
        |=> event_flag_out)
        else $error("fall not captured");
    cap_both_a : assert property (@(posedge core_clk_in) // [RULE10]
        disable iff (!resetn_in)
        clk_en_in && enabled && mode == `CCPU_MODE_CAP_BOTH && (rise || fall)
        |=> event_flag_out)
        else $error("edge not captured");
    cap_quiet_a : assert property (@(posedge core_clk_in) // [RULE9]
        disable iff (!resetn_in)
        clk_en_in && kind_of(mode) == ccpu_pkg::CCPU_KIND_CAPTURE
        && !rise && !fall |=> !event_flag_out)
        else $error("capture without edge");
    ro_bits_a : assert property (@(posedge core_clk_in) // [RULE2]
        disable iff (!resetn_in)
        clk_en_in && req && avs_write_in && avs_address_in == 5'h0
        |=> !st_reg.control[5] && !st_reg.control[6])
        else $error("read-only bit written");
    oe_capture_a : assert property (@(posedge core_clk_in) // [RULE19]
        disable iff (!resetn_in)
        kind_of(mode) == ccpu_pkg::CCPU_KIND_CAPTURE |-> !pin_oe_out)
        else $error("pin driven in capture");
    src_none_a : assert property (@(posedge core_clk_in) // [RULE18]
        disable iff (!resetn_in)
        clk_en_in && st_reg.cap_source[2:1] == 2'h3
        |=> !st_reg.trig_sync[0])
        else $error("reserved source connected");
    sync_chain_a : assert property (@(posedge core_clk_in) // [RULE27]
        disable iff (!resetn_in)
        clk_en_in |=> st_reg.trig_sync[2:1] == $past(st_reg.trig_sync[1:0]))
        else $error("trigger sync broken");
endmodule
`default_nettype wire

/* File: dv/ccpu_timer_model.sv */
// behavioural timers and time base on the far side of the unit
// assumes the unit's clock and reset; one counter serves all three timers
`default_nettype none
module ccpu_timer_model (
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    input  wire logic        run_in,
    input  wire logic        clear_in,
    input  wire logic [7:0]  limit_in,
    input  wire logic [1:0]  which_in,
    output logic      [15:0] t16_out,
    output logic      [7:0]  count_out,
    output logic      [1:0]  low_out,
    output logic      [2:0]  match_out
);
    timeunit 1ns;
    timeprecision 1ns;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            t16_out <= 16'h0000;
            count_out <= 8'h00;
            low_out <= 2'h0;
        end else begin
            if (clear_in)
                t16_out <= 16'h0000;
            else if (run_in)
                t16_out <= t16_out + 16'h0001;
            // quarter-clock base for the period timer
            low_out <= low_out + 2'h1;
            if (low_out == 2'h3)
                count_out <= (count_out == limit_in) ? 8'h00 :
                             count_out + 8'h01;
        end
    end
    // wrap pulse on the chosen timer only, none for the reserved code
    always_comb begin
        match_out = 3'h0;
        if (low_out == 2'h3 && count_out == limit_in && which_in != 2'h3)
            match_out[which_in] = 1'b1;
    end
endmodule
`default_nettype wire

/* File: dv/ccpu_unit_bench.sv */
// self-checking bench for the capture/compare/pulse unit
// assumes ccpu_timer_model drives the timers; triggers come from here
`include "ccpu_params.svh"
`default_nettype none
module ccpu_unit_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic [31:0] wdat = 32'h0, rdat, r;
    logic        wt, pout, oe, tclr, evf, run = 1'b0;
    logic [5:0]  trig = 6'h00;
    logic [7:0]  limit = 8'h09;
    logic [1:0]  which = 2'h0, tsel;
    logic [15:0] t16;
    logic [7:0]  cnt8;
    logic [1:0]  low2;
    logic [2:0]  match;
    logic [31:0] expq[$];
    logic [3:0]  cm[5] = '{4'h5, 4'h6, 4'h7, 4'h4, 4'h3};
    logic [31:0] ce[5] = '{32'h10, 32'h4, 32'h1, 32'h10, 32'h20};
    int mismatches = 0, checks = 0, evn = 0, clrn = 0, e0, hi;
    ccpu_unit ccpu_unit_i (.core_clk_in(clk), .resetn_in(rstn),
        .clk_en_in(1'b1), .avs_address_in(adr), .avs_read_in(rd),
        .avs_write_in(wr), .avs_writedata_in(wdat), .avs_readdata_out(rdat),
        .avs_waitrequest_out(wt), .sixteen_bit_timer_in(t16),
        .period_timer_count_in(cnt8), .period_match_in(match),
        .timer_low_bits_in(low2), .unit_pin_in(trig[0]),
        .comparator_one_synced_in(trig[1]),
        .comparator_two_synced_in(trig[2]),
        .pin_change_interrupt_in(trig[3]),
        .logic_cell_one_output_in(trig[4]),
        .logic_cell_two_output_in(trig[5]), .pulse_out(pout),
        .pin_oe_out(oe), .timer_clear_out(tclr), .event_flag_out(evf),
        .pulse_timer_sel_out(tsel));
    ccpu_timer_model ccpu_timer_model_i (.clk_in(clk), .resetn_in(rstn),
        .run_in(run), .clear_in(tclr), .limit_in(limit), .which_in(which),
        .t16_out(t16), .count_out(cnt8), .low_out(low2), .match_out(match));
    always #50 clk = ~clk;
    always @(posedge clk) begin
        if (evf === 1'b1) evn++;
        if (tclr === 1'b1) clrn++;
        if (rd && wt === 1'b0) chk("readdata", expq.pop_front(), rdat);
    end
    task automatic conclude;
        if (mismatches == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, s);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input [31:0] d);
        int n;
        n = 0;
        adr <= a;
        wdat <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        while (wt !== 1'b0 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n == 50) begin
            mismatches++;
            conclude();
        end
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdreg(input logic [4:0] a, input logic [31:0] e);
        expq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic pulse;
        for (int b = 0; b < 6; b++) begin
            trig[b] <= 1'b1;
            repeat (4) @(posedge clk);
            trig[b] <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask
    task automatic cmp(input logic [3:0] m, input logic e);
        logic [15:0] tg;
        int n;
        tg = t16 + 16'h0014;
        n = clrn;
        bus(1'b1, `CCPU_OFS_VALUE_LOW, {24'h0, tg[7:0]});
        bus(1'b1, `CCPU_OFS_VALUE_HIGH, {24'h0, tg[15:8]});
        bus(1'b1, `CCPU_OFS_CONTROL, {24'h0, 4'h8, m});
        e0 = evn;
        run <= 1'b1;
        repeat (30) @(posedge clk);
        run <= 1'b0;
        chk("match flag", 32'h1, 32'(evn - e0));
        chk("output", {31'h0, e}, {31'h0, pout});
        chk("timer clears", 32'((m == 4'h1 || m == 4'hB) ? 1 : 0),
            32'(clrn - n));
        chk("pin enable", 32'h1, {31'h0, oe});
    endtask
    task automatic pwm(input logic [1:0] s, input logic al,
                       input logic [9:0] d, input logic [31:0] e);
        bus(1'b1, `CCPU_OFS_TIMER_SEL, {30'h0, s});
        which <= s;
        bus(1'b1, `CCPU_OFS_VALUE_LOW, {24'h0, al ? {d[1:0], 6'h3F} : d[7:0]});
        bus(1'b1, `CCPU_OFS_VALUE_HIGH, {24'h0, al ? d[9:2] : {6'h3F, d[9:8]}});
        bus(1'b1, `CCPU_OFS_CONTROL, {24'h0, 3'h4, al, 2'h3, ~s});
        repeat (90) @(posedge clk);
        hi = 0;
        repeat (40) begin
            @(posedge clk);
            if (pout === 1'b1) hi++;
        end
        chk("high cycles", e, 32'(hi));
    endtask
    initial begin
        void'($urandom(31));
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        for (int a = 0; a < 5; a++)
            rdreg(5'(a * 4), 32'h0);
        chk("pin enable", 32'h0, {31'h0, oe});
        rdreg(5'h14, 32'h0);
        bus(1'b1, `CCPU_OFS_CAP_SOURCE, 32'hFF);
        rdreg(`CCPU_OFS_CAP_SOURCE, 32'h7);
        bus(1'b1, `CCPU_OFS_CONTROL, 32'hE5);
        rdreg(`CCPU_OFS_CONTROL, 32'h85);
        r = $urandom;
        bus(1'b1, `CCPU_OFS_TIMER_SEL, r);
        rdreg(`CCPU_OFS_TIMER_SEL, {24'h0, r[7:0]});
        chk("timer field", {30'h0, r[1:0]}, {30'h0, tsel});
        run <= 1'b1;
        repeat (($urandom % 200) + 40) @(posedge clk);
        run <= 1'b0;
        for (int s = 0; s < 8; s++) begin
            bus(1'b1, `CCPU_OFS_CAP_SOURCE, 32'(s));
            e0 = evn;
            pulse();
            chk("source events", 32'(s < 6), 32'(evn - e0));
        end
        bus(1'b1, `CCPU_OFS_CAP_SOURCE, 32'h0);
        bus(1'b1, `CCPU_OFS_CONTROL, 32'h05);
        e0 = evn;
        pulse();
        chk("disabled events", 32'h0, 32'(evn - e0));
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, `CCPU_OFS_CONTROL, 32'h0);
            bus(1'b1, `CCPU_OFS_CONTROL, {24'h0, 4'h8, cm[i]});
            e0 = evn;
            repeat (16) pulse();
            chk("capture events", ce[i], 32'(evn - e0));
        end
        rdreg(`CCPU_OFS_VALUE_LOW, {24'h0, t16[7:0]});
        rdreg(`CCPU_OFS_VALUE_HIGH, {24'h0, t16[15:8]});
        cmp(4'h8, 1'b1);
        cmp(4'h9, 1'b0);
        cmp(4'h2, 1'b1);
        cmp(4'h1, 1'b0);
        cmp(4'hA, 1'b0);
        cmp(4'hB, 1'b0);
        pwm(2'h0, 1'b0, 10'h014, 32'h14);
        pwm(2'h1, 1'b1, 10'h00C, 32'h0C);
        pwm(2'h2, 1'b0, 10'h000, 32'h00);
        pwm(2'h0, 1'b1, 10'h03C, 32'h28);
        conclude();
    end
endmodule
`default_nettype wire
